// ==== logic/anp_regs.v ====
`timescale 1ns/1ps
`include "anp_consts.vh"
// What this block does
// - partner ability bit 15 shows partner has next pages to send.
// - partner ability bit 14 shows partner link code word received.
// - partner ability bit 13 copies partner remote fault, no action taken.
// - partner selector in bits 4:0, cleared on restart or reset.
// - partner abilities in bits 9:5, cleared on restart or reset.
// - expansion bit 4 latches parallel-detect fault, cleared on read or reset.
// - expansion bit 3 always equals partner ability bit 15.
// - expansion bit 2 is fixed at one.
// - expansion bit 1 latches on page received, held until reset.
// - expansion bit 0 set once partner known to negotiate.
// - transmit bit 15 one means more next pages follow.
// - transmit bit 13 selects message or unformatted page, reset one.
// - transmit bit 12 advertises ability to comply with message.
// - transmit toggle bit 11 is inverse of last sent toggle.
// - transmit bits 10:0 hold eleven-bit code, reset value one.
// - received next page captured read-only with all its fields.
module anp_regs (
   clk_sys,
   rst_b,
   an_restart,
   base_page_valid,
   base_page_word,
   next_page_valid,
   next_page_word,
   page_acked,
   pd_fault,
   partner_an_able,
   partner_non_comply,
   tx_page_sent,
   tx_toggle_sent,
   mgmt_addr,
   mgmt_wr,
   mgmt_rd,
   mgmt_wdata,
   mgmt_rdata,
   np_transmit_word
);
   input         clk_sys;
   input         rst_b;
   input         an_restart;
   input         base_page_valid;
   input  [15:0] base_page_word;
   input         next_page_valid;
   input  [15:0] next_page_word;
   input         page_acked;
   input         pd_fault;
   input         partner_an_able;
   input         partner_non_comply;
   input         tx_page_sent;
   input         tx_toggle_sent;
   input  [4:0]  mgmt_addr;
   input         mgmt_wr;
   input         mgmt_rd;
   input  [15:0] mgmt_wdata;
   output [15:0] mgmt_rdata;
   output [15:0] np_transmit_word;

   // partner ability fields, cleared by chip reset and by restart
   reg           pa_next_page_r;
   reg           pa_next_page_nxt;
   reg           pa_ack_r;
   reg           pa_ack_nxt;
   reg           pa_remote_fault_r;
   reg           pa_remote_fault_nxt;
   reg    [1:0]  pa_pause_r;
   reg    [1:0]  pa_pause_nxt;
   reg    [4:0]  pa_sel_r;
   reg    [4:0]  pa_sel_nxt;
   wire   [4:0]  pa_abil;

   // transmit page fields
   reg           npt_next_page_r;
   reg           npt_next_page_nxt;
   reg           npt_msg_page_r;
   reg           npt_msg_page_nxt;
   reg           npt_comply_r;
   reg           npt_comply_nxt;
   reg           npt_toggle_r;
   reg           npt_toggle_nxt;
   reg    [10:0] npt_code_r;
   reg    [10:0] npt_code_nxt;

   // expansion latches
   reg           pd_fault_r;
   reg           pd_fault_nxt;
   reg           page_rcvd_r;
   reg           page_rcvd_nxt;
   reg           an_able_r;
   reg           an_able_nxt;

   // register views as the host sees them
   wire   [15:0] pa_val;
   wire   [15:0] ex_val;
   wire   [15:0] npt_val;
   wire   [15:0] npr_val;
   wire          ex_read;
   wire          npt_write;
   genvar        g;

   localparam ABIL_BITS = 5;
   localparam WORD_BITS = 16;

   // true when a management strobe targets the given register address
   function addr_hit;
      input       strobe;
      input [4:0] addr;
      input [4:0] target;
      begin
         addr_hit = strobe && (addr == target);
      end
   endfunction

   assign ex_read   = addr_hit(mgmt_rd, mgmt_addr, `ANP_ADDR_EXPANSION);
   assign npt_write = addr_hit(mgmt_wr, mgmt_addr, `ANP_ADDR_NP_TRANSMIT);

   // base page capture; restart has priority over a page arriving in the same cycle
   always @* begin
      pa_next_page_nxt    = pa_next_page_r;
      pa_ack_nxt          = pa_ack_r;
      pa_remote_fault_nxt = pa_remote_fault_r;
      pa_pause_nxt        = pa_pause_r;
      pa_sel_nxt          = pa_sel_r;
      if (an_restart) begin
         pa_next_page_nxt    = 1'h0;
         pa_ack_nxt          = 1'h0;
         pa_remote_fault_nxt = 1'h0;
         pa_pause_nxt        = 2'h0;
         pa_sel_nxt          = 5'h00;
      end else if (base_page_valid) begin
         pa_next_page_nxt    = base_page_word[`ANP_PA_NEXT_PAGE];
         pa_ack_nxt          = base_page_word[`ANP_PA_ACK];
         pa_remote_fault_nxt = base_page_word[`ANP_PA_REMOTE_FAULT];
         pa_pause_nxt        = base_page_word[`ANP_PA_PAUSE_HI:`ANP_PA_PAUSE_LO];
         pa_sel_nxt          = base_page_word[`ANP_PA_SEL_HI:`ANP_PA_SEL_LO];
      end
   end

   // partner ability flops
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pa_next_page_r <= 1'h0;
      end else begin
         pa_next_page_r <= pa_next_page_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pa_ack_r <= 1'h0;
      end else begin
         pa_ack_r <= pa_ack_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pa_remote_fault_r <= 1'h0;
      end else begin
         pa_remote_fault_r <= pa_remote_fault_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pa_pause_r <= 2'h0;
      end else begin
         pa_pause_r <= pa_pause_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pa_sel_r <= 5'h00;
      end else begin
         pa_sel_r <= pa_sel_nxt;
      end
   end

   // one flop per ability bit, all under the same clear and capture rules
   generate
      for (g = 0; g < ABIL_BITS; g = g + 1) begin : g_abil
         reg abil_r;
         always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               abil_r <= 1'h0;
            end else if (an_restart) begin
               abil_r <= 1'h0;
            end else if (base_page_valid) begin
               abil_r <= base_page_word[`ANP_PA_ABIL_LO + g];
            end
         end
         assign pa_abil[g] = abil_r;
      end
   endgenerate

   // bit 12 is reserved and always reads zero
   assign pa_val = {pa_next_page_r, pa_ack_r, pa_remote_fault_r, 1'h0, pa_pause_r, pa_abil, pa_sel_r};

   // received next page: taken whole, not touched by restart
   generate
      for (g = 0; g < WORD_BITS; g = g + 1) begin : g_npr
         reg npr_bit_r;
         always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               npr_bit_r <= 1'h0;
            end else if (next_page_valid) begin
               npr_bit_r <= next_page_word[g];
            end
         end
         assign npr_val[g] = npr_bit_r;
      end
   endgenerate

   // expansion latches: a new event in the read cycle wins over the clear
   always @* begin
      pd_fault_nxt  = pd_fault_r;
      page_rcvd_nxt = page_rcvd_r;
      an_able_nxt   = an_able_r;
      if (pd_fault) begin
         pd_fault_nxt = 1'h1;
      end else if (ex_read) begin
         pd_fault_nxt = 1'h0;
      end
      if (page_acked) begin
         page_rcvd_nxt = 1'h1;
      end
      if (an_restart || partner_non_comply) begin
         an_able_nxt = 1'h0;
      end else if (partner_an_able) begin
         an_able_nxt = 1'h1;
      end
   end

   // expansion flops
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pd_fault_r <= 1'h0;
      end else begin
         pd_fault_r <= pd_fault_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         page_rcvd_r <= 1'h0;
      end else begin
         page_rcvd_r <= page_rcvd_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         an_able_r <= 1'h0;
      end else begin
         an_able_r <= an_able_nxt;
      end
   end

   // partner next page ability mirrors the captured base page bit
   assign ex_val = {11'h000, pd_fault_r, pa_next_page_r, 1'h1, page_rcvd_r, an_able_r};

   // transmit page: host writes all but bits 14 and 11, the toggle follows the line side
   always @* begin
      npt_next_page_nxt = npt_next_page_r;
      npt_msg_page_nxt  = npt_msg_page_r;
      npt_comply_nxt    = npt_comply_r;
      npt_code_nxt      = npt_code_r;
      npt_toggle_nxt    = npt_toggle_r;
      if (npt_write) begin
         npt_next_page_nxt = mgmt_wdata[`ANP_NP_NEXT_PAGE];
         npt_msg_page_nxt  = mgmt_wdata[`ANP_NP_MSG_PAGE];
         npt_comply_nxt    = mgmt_wdata[`ANP_NP_COMPLY_ACK];
         npt_code_nxt      = mgmt_wdata[`ANP_NP_CODE_HI:`ANP_NP_CODE_LO];
      end
      if (an_restart) begin
         npt_toggle_nxt = 1'h0;
      end else if (tx_page_sent) begin
         npt_toggle_nxt = ~tx_toggle_sent;
      end
   end

   // transmit flops; message page and code leave reset at one
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         npt_next_page_r <= 1'h0;
      end else begin
         npt_next_page_r <= npt_next_page_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         npt_msg_page_r <= `ANP_NPT_MSG_RESET;
      end else begin
         npt_msg_page_r <= npt_msg_page_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         npt_comply_r <= 1'h0;
      end else begin
         npt_comply_r <= npt_comply_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         npt_toggle_r <= 1'h0;
      end else begin
         npt_toggle_r <= npt_toggle_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         npt_code_r <= `ANP_NPT_CODE_RESET;
      end else begin
         npt_code_r <= npt_code_nxt;
      end
   end

   // bit 14 is reserved and always reads zero
   assign npt_val = {npt_next_page_r, 1'h0, npt_msg_page_r, npt_comply_r, npt_toggle_r, npt_code_r};

   // the line side sends exactly what the host reads back
   assign np_transmit_word = npt_val;

   // read data is registered and holds until the next read
   anp_rd_mux u_anp_rd_mux (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .rd_en   (mgmt_rd),
      .addr    (mgmt_addr),
      .pa_val  (pa_val),
      .ex_val  (ex_val),
      .npt_val (npt_val),
      .npr_val (npr_val),
      .rd_data (mgmt_rdata)
   );
endmodule

// ==== logic/anp_consts.vh ====
`ifndef ANP_CONSTS_VH
`define ANP_CONSTS_VH
// register addresses on the management port
`define ANP_ADDR_PARTNER_ABILITY   5'h05
`define ANP_ADDR_EXPANSION         5'h06
`define ANP_ADDR_NP_TRANSMIT       5'h07
`define ANP_ADDR_NP_RECEIVED       5'h08
// partner ability fields
`define ANP_PA_NEXT_PAGE           15
`define ANP_PA_ACK                 14
`define ANP_PA_REMOTE_FAULT        13
`define ANP_PA_ABIL_HI             9
`define ANP_PA_ABIL_LO             5
`define ANP_PA_SEL_HI              4
`define ANP_PA_SEL_LO              0
`define ANP_PA_PAUSE_HI            11
`define ANP_PA_PAUSE_LO            10
`define ANP_PA_KEEP_MASK           16'hEFFF
// expansion fields
`define ANP_EX_PD_FAULT            4
`define ANP_EX_PARTNER_NP_ABLE     3
`define ANP_EX_LOCAL_NP_ABLE       2
`define ANP_EX_PAGE_RECEIVED       1
`define ANP_EX_PARTNER_AN_ABLE     0
// next page fields (transmit and received)
`define ANP_NP_NEXT_PAGE           15
`define ANP_NP_ACK                 14
`define ANP_NP_MSG_PAGE            13
`define ANP_NP_COMPLY_ACK          12
`define ANP_NP_TOGGLE              11
`define ANP_NP_CODE_HI             10
`define ANP_NP_CODE_LO             0
// reset values
`define ANP_NPT_RESET              16'h2001
`define ANP_NPT_MSG_RESET          1'h1
`define ANP_NPT_CODE_RESET         11'h001
`define ANP_NPT_WRITE_MASK         16'hB7FF
`define ANP_ZERO16                 16'h0000
`endif

// ==== logic/anp_rd_mux.v ====
`timescale 1ns/1ps
`include "anp_consts.vh"
// read data selection, registered
module anp_rd_mux (
   clk_sys,
   rst_b,
   rd_en,
   addr,
   pa_val,
   ex_val,
   npt_val,
   npr_val,
   rd_data
);
   input         clk_sys;
   input         rst_b;
   input         rd_en;
   input  [4:0]  addr;
   input  [15:0] pa_val;
   input  [15:0] ex_val;
   input  [15:0] npt_val;
   input  [15:0] npr_val;
   output [15:0] rd_data;
   reg    [15:0] rd_data;
   reg    [15:0] sel;

   always @* begin
      case (addr)
         `ANP_ADDR_PARTNER_ABILITY: sel = pa_val;
         `ANP_ADDR_EXPANSION:       sel = ex_val;
         `ANP_ADDR_NP_TRANSMIT:     sel = npt_val;
         `ANP_ADDR_NP_RECEIVED:     sel = npr_val;
         default:                   sel = `ANP_ZERO16;
      endcase
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= `ANP_ZERO16;
      end else if (rd_en) begin
         rd_data <= sel;
      end
   end
endmodule

// ==== test/anp_partner.sv ====
`timescale 1ns/1ps
// link partner: a page a cycle after asked, word scrambled while idle
module anp_partner (
   input  wire        clk_sys,
   input  wire        send_base,
   input  wire        send_next,
   input  wire [15:0] page_word,
   output reg         base_page_valid = 1'b0,
   output reg  [15:0] base_page_word = 16'h0000,
   output reg         next_page_valid = 1'b0,
   output reg  [15:0] next_page_word = 16'h0000,
   output reg         page_acked = 1'b0
);
   always @(posedge clk_sys) begin
      base_page_valid <= send_base;
      next_page_valid <= send_next;
      page_acked      <= base_page_valid | next_page_valid;
      base_page_word  <= send_base ? page_word : ~base_page_word;
      next_page_word  <= send_next ? page_word : ~next_page_word;
   end
endmodule

// ==== test/anp_regs_props.sv ====
`timescale 1ns/1ps
module anp_regs_props (
   input wire        clk_sys,
   input wire        rst_b,
   input wire        an_restart,
   input wire        base_page_valid,
   input wire [15:0] base_page_word,
   input wire        pd_fault,
   input wire        page_acked,
   input wire [4:0]  mgmt_addr,
   input wire        mgmt_rd,
   input wire [15:0] mgmt_rdata
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire rd5 = mgmt_rd && mgmt_addr == 5'h05;
   wire rd6 = mgmt_rd && mgmt_addr == 5'h06;
   sequence s_cap(r);
      base_page_valid && !an_restart ##1 r && !base_page_valid && !an_restart;
   endsequence
   a_exp_fixed: assert property (rd6 |=> mgmt_rdata[15:5] == 11'h000 && mgmt_rdata[2])
      else $error("expansion fixed bits wrong");
   a_pa_reserved: assert property (rd5 |=> !mgmt_rdata[12])
      else $error("reserved ability bit set");
   a_pa_capture: assert property (s_cap(rd5) |=> mgmt_rdata == ($past(base_page_word, 2) & 16'hEFFF))
      else $error("ability word not captured");
   a_np_mirror: assert property (s_cap(rd6) |=> mgmt_rdata[3] == $past(base_page_word[15], 2))
      else $error("next page able not mirrored");
   a_pd_latch: assert property (pd_fault ##1 rd6 |=> mgmt_rdata[4])
      else $error("fault not latched");
   a_pd_clear: assert property (rd6 && !pd_fault ##1 rd6 |=> !mgmt_rdata[4])
      else $error("fault not cleared by read");
   a_page_sticky: assert property (page_acked ##1 rd6 |=> mgmt_rdata[1])
      else $error("page received not set");
   a_restart_clear: assert property (an_restart ##1 rd5 && !base_page_valid |=> mgmt_rdata == 16'h0000)
      else $error("ability not cleared on restart");
endmodule
bind anp_regs anp_regs_props u_anp_regs_props (.clk_sys(clk_sys), .rst_b(rst_b), .an_restart(an_restart),
   .base_page_valid(base_page_valid), .base_page_word(base_page_word), .pd_fault(pd_fault),
   .page_acked(page_acked), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata));

// ==== test/anp_regs_tb_top.sv ====
`timescale 1ns/1ps
module anp_regs_tb_top;
   reg         clk_sys, rst_b, an_restart, pd_fault, an_able, non_comply, tx_sent, tx_tog;
   reg         send_base, send_next, mgmt_wr, mgmt_rd, m_pd, m_pg, m_ab, pend, t;
   reg  [15:0] mgmt_wdata, pw, m_pa, m_npr, m_npt, exp_rd;
   reg  [4:0]  mgmt_addr;
   reg  [31:0] r;
   wire [15:0] mgmt_rdata, bw, nw, ntw;
   wire        bv, nv, acked;
   integer     bad_count = 0, samples_checked = 0, cyc = 0, n;
   initial begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   anp_partner u_anp_partner (.clk_sys(clk_sys), .send_base(send_base), .send_next(send_next), .page_word(pw),
      .base_page_valid(bv), .base_page_word(bw), .next_page_valid(nv), .next_page_word(nw), .page_acked(acked));
   anp_regs u_anp_regs (.clk_sys(clk_sys), .rst_b(rst_b), .an_restart(an_restart), .base_page_valid(bv),
      .base_page_word(bw), .next_page_valid(nv), .next_page_word(nw), .page_acked(acked), .pd_fault(pd_fault),
      .partner_an_able(an_able), .partner_non_comply(non_comply), .tx_page_sent(tx_sent), .tx_toggle_sent(tx_tog),
      .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata), .np_transmit_word(ntw));
   task end_sim;
      begin
         $display("checked=%0d bad=%0d", samples_checked, bad_count);
         if (bad_count == 0 && samples_checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task cmp(input [15:0] got, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task cmp_tx(input [15:0] got, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH t=%0t tx got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   function [15:0] rd_exp(input [4:0] a);
      case (a)
         5'h05: rd_exp = m_pa;
         5'h06: rd_exp = {11'h000, m_pd, m_pa[15], 1'b1, m_pg, m_ab};
         5'h07: rd_exp = m_npt;
         5'h08: rd_exp = m_npr;
         default: rd_exp = 16'h0000;
      endcase
   endfunction
   // reference model, updated from the values the design samples at this edge
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {m_pa, m_npr, m_pd, m_pg, m_ab, pend} <= 0;
         m_npt <= 16'h2001;
      end else begin
         if (pend)
            cmp(mgmt_rdata, exp_rd);
         cmp_tx(ntw, m_npt);
         pend <= mgmt_rd;
         if (mgmt_rd)
            exp_rd <= rd_exp(mgmt_addr);
         m_pd <= pd_fault | (m_pd & ~(mgmt_rd & mgmt_addr == 5'h06));
         m_pg <= m_pg | acked;
         m_ab <= ~(non_comply | an_restart) & (m_ab | an_able);
         if (an_restart)
            m_pa <= 16'h0000;
         else if (bv)
            m_pa <= bw & 16'hEFFF;
         if (nv)
            m_npr <= nw;
         t = an_restart ? 1'b0 : tx_sent ? ~tx_tog : m_npt[11];
         m_npt <= ((mgmt_wr && mgmt_addr == 5'h07) ? mgmt_wdata & 16'hB7FF : m_npt & 16'hB7FF) | {4'h0, t, 11'h000};
      end
   end
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         bad_count = bad_count + 1;
         end_sim;
      end
   end
   initial begin
      {rst_b, an_restart, pd_fault, an_able, non_comply, tx_sent, tx_tog, send_base, send_next, mgmt_wr} = 0;
      {mgmt_rd, mgmt_wdata, pw, mgmt_addr} = 0;
      r = $urandom(32'h134D47C8);
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      // first four reads walk back-to-back from address 8 down to 5, while random stimulus starts in the same cycle
      for (n = 0; n < 3000; n = n + 1) begin
         r = $urandom;
         mgmt_rd <= r[0] | (n < 4);
         mgmt_wr <= r[1] & (n >= 4);
         mgmt_addr <= (n < 4) ? 5'h08 - n[4:0] : r[4] ? 5'h05 + r[6:5] : r[11:7];
         mgmt_wdata <= $urandom;
         pw <= $urandom;
         an_restart <= (r[15:12] == 4'h0) & ~send_base;
         send_base <= r[17:16] == 2'h0;
         send_next <= r[19:18] == 2'h0;
         pd_fault <= r[22:20] == 3'h0;
         an_able <= r[24:23] == 2'h0;
         non_comply <= r[27:25] == 3'h0;
         tx_sent <= r[28] & (r[15:12] != 4'h0);
         tx_tog <= r[29];
         @(posedge clk_sys);
      end
      end_sim;
   end
endmodule
